/* rtl/stq_pkg.sv */
// shared constants and types for the second-tier interrupt flag and mask block
package stq_pkg;
  localparam logic [7:0] CHG_MASK_OFFSET = 8'h05;
  localparam logic [7:0] REG_FLAGS_OFFSET = 8'h06;
  localparam logic [7:0] REG_MASK_OFFSET = 8'h07;
  localparam logic [7:0] CHG_MASK_RESET = 8'h7F;
  localparam logic [7:0] REG_FLAGS_RESET = 8'h00;
  localparam logic [7:0] REG_MASK_RESET = 8'hFF;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // edges after reset before a change flag may fire: sync refill plus first take
  localparam logic [1:0] SETTLE_EDGES = 2'h3;
  localparam int CHG_EVENT_COUNT = 7;
  localparam int REG_EVENT_COUNT = 4;
  // positions inside the regulator flag and mask registers
  localparam int BUCK_A_POS = 3;
  localparam int BUCK_B_POS = 2;
  localparam int LINREG_A_POS = 1;
  localparam int LINREG_B_POS = 0;
  // positions inside the charger mask register
  localparam int DEAD_TIMER_POS = 6;
  localparam int INPUT_LIMIT_POS = 5;
  localparam int FAST_TIMER_POS = 4;
  localparam int PREQUAL_TIMER_POS = 3;
  localparam int BATT_PRESENT_POS = 2;
  localparam int BATT_STATUS_POS = 1;
  localparam int CHARGER_STATUS_POS = 0;
  localparam int RESERVED_BIT_POS = 7;

  // output-good levels, packed in flag-bit order (bit 3 down to bit 0)
  typedef struct packed {
    logic buck_a_good;
    logic buck_b_good;
    logic linreg_a_good;
    logic linreg_b_good;
  } stq_good_t;

  // one register access from the serial bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stq_reg_req_t;
endpackage : stq_pkg

/* rtl/stq_change_flag.sv */
// one latched change flag for an output-good level
`timescale 1ns/100ps
`default_nettype none
module stq_change_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic clear,
  output var logic flag
);
  import stq_pkg::*;

  logic last_level;
  logic [1:0] settle;
  logic change;

  // the synchroniser ahead still shows its reset zeros for two edges,
  // so no edge is claimed until real levels have been taken
  assign change = (settle == SETTLE_EDGES) && (level != last_level);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_level <= 1'b0;
      settle <= 2'h0;
    end else begin
      last_level <= level;
      if (settle != SETTLE_EDGES) begin
        settle <= settle + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (change) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule : stq_change_flag
`default_nettype wire

/* rtl/stq_irq_regs.sv */
// charger mask, regulator flag and regulator mask registers with summary bits
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - charger mask bits gate seven events, reset one
// - regulator flag register at 0x06, reset zero
// - buck changes set flag bits 3, 2
// - linear regulator changes set bits 1, 0
// - unmasked regulator flags drive summary bits
// - regulator mask at 0x07, resets all ones
// - unmasked charger flag drives charger summary
// - regulator change flags latch until cleared
module stq_irq_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire stq_pkg::stq_reg_req_t REG_REQ,
  input wire stq_pkg::stq_good_t GOOD,
  input wire logic [6:0] CHG_FLAGS,
  output var logic [7:0] REG_RDATA,
  output var logic SWITCHER_SUMMARY_BIT,
  output var logic LINREG_SUMMARY_BIT,
  output var logic CHARGER_SUMMARY_BIT
);
  import stq_pkg::*;

  logic [7:0] charger_event_mask;
  logic [7:0] regulator_event_mask;
  logic [7:0] next_chg_mask;
  logic [7:0] next_reg_mask;
  logic [3:0] change_flags;
  logic [3:0] flag_clear;
  logic [3:0] good_meta;
  logic [3:0] good_sync;
  logic [7:0] next_rdata;
  logic [7:0] flag_view;
  logic [3:0] open_flags;
  logic [6:0] open_chg;
  logic [6:0] chg_gate;
  logic wr_chg_mask;
  logic wr_reg_flags;
  logic wr_reg_mask;
  logic next_switcher;
  logic next_linreg;
  logic next_charger;

  // named field views, so the gating below reads event by event
  logic dead_timer_gate;
  logic input_limit_gate;
  logic fast_timer_gate;
  logic prequal_timer_gate;
  logic batt_present_gate;
  logic batt_status_gate;
  logic charger_status_gate;
  logic buck_a_flag_gate;
  logic buck_b_flag_gate;
  logic linreg_a_flag_gate;
  logic linreg_b_flag_gate;
  logic buck_a_change_flag;
  logic buck_b_change_flag;
  logic linreg_a_change_flag;
  logic linreg_b_change_flag;

  function automatic logic hit(input stq_reg_req_t req, input logic [7:0] offset);
    hit = (req.addr == offset);
  endfunction : hit

  // analog comparators are asynchronous to this clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      good_meta <= 4'h0;
      good_sync <= 4'h0;
    end else begin
      good_meta <= GOOD;
      good_sync <= good_meta;
    end
  end

  // register decodes, shared by the write and clear paths
  assign wr_chg_mask = REG_REQ.wr && hit(REG_REQ, CHG_MASK_OFFSET);
  assign wr_reg_flags = REG_REQ.wr && hit(REG_REQ, REG_FLAGS_OFFSET);
  assign wr_reg_mask = REG_REQ.wr && hit(REG_REQ, REG_MASK_OFFSET);

  // reserved mask bits are plain storage and read back as written
  always_comb begin
    next_chg_mask = charger_event_mask;
    if (wr_chg_mask) begin
      next_chg_mask = REG_REQ.wdata;
    end
  end

  always_comb begin
    next_reg_mask = regulator_event_mask;
    if (wr_reg_mask) begin
      next_reg_mask = REG_REQ.wdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      charger_event_mask <= CHG_MASK_RESET;
    end else begin
      charger_event_mask <= next_chg_mask;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      regulator_event_mask <= REG_MASK_RESET;
    end else begin
      regulator_event_mask <= next_reg_mask;
    end
  end

  genvar g;
  // write-one-to-clear; flag bits 7..4 have no storage
  generate
    for (g = 0; g < REG_EVENT_COUNT; g++) begin : g_clear
      assign flag_clear[g] = wr_reg_flags && REG_REQ.wdata[g];
    end
  endgenerate

  // set wins over clear inside each flag, so no change is lost
  generate
    for (g = 0; g < REG_EVENT_COUNT; g++) begin : g_flag
      stq_change_flag u_flag (
        .clk(CLK),
        .rst_n(RST_N),
        .level(good_sync[g]),
        .clear(flag_clear[g]),
        .flag(change_flags[g])
      );
    end
  endgenerate

  assign dead_timer_gate = charger_event_mask[DEAD_TIMER_POS];
  assign input_limit_gate = charger_event_mask[INPUT_LIMIT_POS];
  assign fast_timer_gate = charger_event_mask[FAST_TIMER_POS];
  assign prequal_timer_gate = charger_event_mask[PREQUAL_TIMER_POS];
  assign batt_present_gate = charger_event_mask[BATT_PRESENT_POS];
  assign batt_status_gate = charger_event_mask[BATT_STATUS_POS];
  assign charger_status_gate = charger_event_mask[CHARGER_STATUS_POS];
  assign buck_a_flag_gate = regulator_event_mask[BUCK_A_POS];
  assign buck_b_flag_gate = regulator_event_mask[BUCK_B_POS];
  assign linreg_a_flag_gate = regulator_event_mask[LINREG_A_POS];
  assign linreg_b_flag_gate = regulator_event_mask[LINREG_B_POS];
  assign buck_a_change_flag = change_flags[BUCK_A_POS];
  assign buck_b_change_flag = change_flags[BUCK_B_POS];
  assign linreg_a_change_flag = change_flags[LINREG_A_POS];
  assign linreg_b_change_flag = change_flags[LINREG_B_POS];

  // reassembled in register bit order so one loop gates every charger event
  assign chg_gate = {dead_timer_gate, input_limit_gate, fast_timer_gate, prequal_timer_gate,
                     batt_present_gate, batt_status_gate, charger_status_gate};

  // a flag reaches its summary only while its gate bit is zero
  assign open_flags[BUCK_A_POS] = buck_a_change_flag && !buck_a_flag_gate;
  assign open_flags[BUCK_B_POS] = buck_b_change_flag && !buck_b_flag_gate;
  assign open_flags[LINREG_A_POS] = linreg_a_change_flag && !linreg_a_flag_gate;
  assign open_flags[LINREG_B_POS] = linreg_b_change_flag && !linreg_b_flag_gate;

  // charger flags arrive already latched from their own register
  generate
    for (g = 0; g < CHG_EVENT_COUNT; g++) begin : g_open_chg
      assign open_chg[g] = CHG_FLAGS[g] && !chg_gate[g];
    end
  endgenerate

  // flag register as read: reserved upper bits always zero
  assign flag_view = {4'h0, buck_a_change_flag, buck_b_change_flag,
                      linreg_a_change_flag, linreg_b_change_flag};

  always_comb begin
    next_switcher = open_flags[BUCK_A_POS] || open_flags[BUCK_B_POS];
    next_linreg = open_flags[LINREG_A_POS] || open_flags[LINREG_B_POS];
    next_charger = |open_chg;
  end

  // registered so every summary leaves a flip-flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SWITCHER_SUMMARY_BIT <= 1'b0;
      LINREG_SUMMARY_BIT <= 1'b0;
      CHARGER_SUMMARY_BIT <= 1'b0;
    end else begin
      SWITCHER_SUMMARY_BIT <= next_switcher;
      LINREG_SUMMARY_BIT <= next_linreg;
      CHARGER_SUMMARY_BIT <= next_charger;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    next_rdata = RDATA_RESET;
    case (REG_REQ.addr)
      CHG_MASK_OFFSET: begin
        next_rdata = charger_event_mask;
      end
      REG_FLAGS_OFFSET: begin
        next_rdata = flag_view;
      end
      REG_MASK_OFFSET: begin
        next_rdata = regulator_event_mask;
      end
      default: begin
        next_rdata = RDATA_RESET;
      end
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= RDATA_RESET;
    end else if (REG_REQ.rd) begin
      REG_RDATA <= next_rdata;
    end
  end
endmodule : stq_irq_regs
`default_nettype wire

/* dv/stq_host_model.sv */
// host side register master model
`timescale 1ns/100ps
`default_nettype none
module stq_host_model (
  input wire logic clk,
  output var stq_pkg::stq_reg_req_t req
);
  import stq_pkg::*;
  initial req = '0;
  // a clear is a write of ones, released fields go inverse so stale values fail
  // request starts one edge in, so back-to-back calls never drive twice in one step
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk) #1 req = '{w, !w, a, d};
    @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask : acc
endmodule : stq_host_model
`default_nettype wire

/* dv/stq_irq_regs_assertions.sv */
// port checker for the flag and mask block
`timescale 1ns/100ps
`default_nettype none
module stq_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire stq_pkg::stq_reg_req_t REG_REQ,
  input wire stq_pkg::stq_good_t GOOD,
  input wire logic [6:0] CHG_FLAGS,
  input wire logic [7:0] REG_RDATA,
  input wire logic SWITCHER_SUMMARY_BIT,
  input wire logic LINREG_SUMMARY_BIT,
  input wire logic CHARGER_SUMMARY_BIT
);
  import stq_pkg::*;
  logic [7:0] rm;
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) rm <= 8'hFF;
    else if (REG_REQ.wr && REG_REQ.addr == 8'h07) rm <= REG_REQ.wdata;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence rd_at(a); REG_REQ.rd && REG_REQ.addr == a; endsequence
  sequence flip(b, m); $changed(b) && !m; endsequence
  chk_rd_flags: assert property (rd_at(8'h06) |=> !REG_RDATA[7:4])
    else $error("flags");
  chk_rm_rd: assert property (rd_at(8'h07) |=> REG_RDATA == $past(rm))
    else $error("mask");
  chk_chg_idle: assert property ($past(CHG_FLAGS) == 7'h00 |-> !CHARGER_SUMMARY_BIT)
    else $error("chg");
  chk_sw_mask: assert property (&$past(rm[3:2]) |-> !SWITCHER_SUMMARY_BIT)
    else $error("sw");
  chk_ld_mask: assert property (&$past(rm[1:0]) |-> !LINREG_SUMMARY_BIT)
    else $error("ld");
  chk_bucka_set: assert property (flip(GOOD.buck_a_good, rm[3]) |-> ##[1:5] SWITCHER_SUMMARY_BIT)
    else $error("bucka");
  chk_buckb_set: assert property (flip(GOOD.buck_b_good, rm[2]) |-> ##[1:5] SWITCHER_SUMMARY_BIT)
    else $error("buckb");
  chk_ldo_set: assert property (flip(GOOD.linreg_b_good, rm[0]) |-> ##[1:5] LINREG_SUMMARY_BIT)
    else $error("ldo");
  chk_lina_set: assert property (flip(GOOD.linreg_a_good, rm[1]) |-> ##[1:5] LINREG_SUMMARY_BIT)
    else $error("lina");
endmodule : stq_chk
bind stq_irq_regs stq_chk chk (.CLK, .RST_N, .REG_REQ, .GOOD, .CHG_FLAGS, .REG_RDATA,
  .SWITCHER_SUMMARY_BIT, .LINREG_SUMMARY_BIT, .CHARGER_SUMMARY_BIT);
`default_nettype wire

/* dv/stq_irq_regs_bench.sv */
// bench for the flag and mask block
`timescale 1ns/100ps
`default_nettype none
module stq_irq_regs_bench;
  import stq_pkg::*;
  logic clk = 0, rst_n = 0, sw, ld, cs;
  logic [6:0] chg = '0;
  logic [7:0] rdata;
  stq_reg_req_t req;
  stq_good_t good = '0;
  int fails = 0, n_checks = 0, cyc = 0;
  stq_host_model host (.clk(clk), .req(req));
  stq_irq_regs uut (.CLK(clk), .RST_N(rst_n), .REG_REQ(req), .GOOD(good), .CHG_FLAGS(chg),
    .REG_RDATA(rdata), .SWITCHER_SUMMARY_BIT(sw), .LINREG_SUMMARY_BIT(ld),
    .CHARGER_SUMMARY_BIT(cs));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 900) tally_and_finish();
  task automatic ck(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask : ck
  task automatic tally_and_finish();
    // a run cut short by the cycle ceiling counts as a mismatch
    fails += (cyc >= 900);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic rd(input logic [7:0] a, exp);
    host.acc(1'b0, a, 8'h00);
    ck(rdata, exp);
  endtask : rd
  task automatic t_chg();
    rd(8'h05, 8'h7F);
    host.acc(1'b1, 8'h05, 8'h80);
    rd(8'h05, 8'h80);
    for (int i = 0; i < 7; i++) begin
      chg = 7'(8'h01 << i);
      host.acc(1'b1, 8'h05, ~(8'h01 << i));
      @(posedge clk) #1 ck(8'(cs), 8'h01);
    end
    host.acc(1'b1, 8'h05, 8'hFF);
    @(posedge clk) #1 ck(8'(cs), 8'h00);
  endtask : t_chg
  task automatic t_reg();
    rd(8'h06, 8'h00);
    rd(8'h07, 8'hFF);
    host.acc(1'b1, 8'h07, 8'hF0);
    rd(8'h07, 8'hF0);
    for (int p = 0; p < 4; p++) begin
      good[p] = ~good[p];
      repeat (5) @(posedge clk);
      #1 ck(8'({sw, ld}), p > 1 ? 8'h02 : 8'h01);
      rd(8'h06, 8'h01 << p);
      host.acc(1'b1, 8'h06, ~(8'h01 << p));
      rd(8'h06, 8'h01 << p);
      host.acc(1'b1, 8'h06, 8'hFF);
      rd(8'h06, 8'h00);
    end
  endtask : t_reg
  // the clear write lands on the very edge at which the change sets the flag
  task automatic t_race();
    good[3] = ~good[3];
    @(posedge clk) #1;
    host.acc(1'b1, 8'h06, 8'hFF);
    rd(8'h06, 8'h08);
    host.acc(1'b1, 8'h06, 8'hFF);
    rd(8'h06, 8'h00);
  endtask : t_race
  // reset in mid-run with live levels on the good inputs
  task automatic t_reset();
    host.acc(1'b1, 8'h05, 8'h00);
    @(posedge clk) #1 ck(8'(cs), 8'h01);
    rst_n = 0;
    #1 ck(8'({sw, ld, cs}), 8'h00);
    ck(rdata, 8'h00);
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    rd(8'h05, 8'h7F);
    rd(8'h07, 8'hFF);
    repeat (6) @(posedge clk);
    #1 rd(8'h06, 8'h00);
  endtask : t_reset
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    t_chg();
    t_reg();
    t_race();
    t_reset();
    tally_and_finish();
  end
endmodule : stq_irq_regs_bench
`default_nettype wire
